// ---- hdl/cfds_consts.svh ----
`ifndef CFDS_CONSTS_SVH
`define CFDS_CONSTS_SVH
// Register indexes, byte address is four times the index
`define CFDS_IDX_FLAGS 14'h0788
`define CFDS_IDX_UART_DISC 14'h0789
`define CFDS_IDX_UPPER_DISC 14'h078a
`define CFDS_IDX_LOWER_DISC 14'h078b
`define CFDS_IDX_VALID_HI 14'h078c
`define CFDS_IDX_VALID_LO 14'h078d
`define CFDS_IDX_IRQ_STAT 14'h07c0
`define CFDS_IDX_IRQ_MASK 14'h07c1
// Error flag bit positions
`define CFDS_FLG_CRC 0
`define CFDS_FLG_UNEXP 1
`define CFDS_FLG_BYTE 2
`define CFDS_FLG_SOF 3
`define CFDS_FLG_TXDIS 4
// Interrupt status bit positions
`define CFDS_IRQ_CRC 0
`define CFDS_IRQ_UNEXP 1
`define CFDS_IRQ_BYTE 2
`define CFDS_IRQ_TXDIS 3
`define CFDS_IRQ_DISC 4
// Port slots of the discard counters
`define CFDS_P_UART 0
`define CFDS_P_UPPER 1
`define CFDS_P_LOWER 2
// Values
`define CFDS_ZERO8 8'h00
`define CFDS_MAX8 8'hff
`define CFDS_MAX16 16'hffff
`define CFDS_RESP_OKAY 2'h0
`define CFDS_RESP_SLVERR 2'h2
`endif

// ---- hdl/cfds_pkg.sv ----
package cfds_pkg;
    typedef logic [15:0] cfds_addr_t;
    typedef logic [31:0] cfds_word_t;
    typedef struct packed {
        logic [7:0] flags_reg;
        logic [2:0][7:0] disc_cnt_reg;
        logic [2:0][7:0] disc_lat_reg;
        logic [15:0] valid_cnt_reg;
        logic [15:0] valid_lat_reg;
        logic [4:0] irq_stat_reg;
        logic [4:0] irq_mask_reg;
        logic aw_held_reg;
        logic [13:0] aw_idx_reg;
        logic w_held_reg;
        logic [7:0] wdata_reg;
        logic wstrb0_reg;
        logic bvalid_reg;
        logic [1:0] bresp_reg;
        logic rvalid_reg;
        logic [31:0] rdata_reg;
        logic [1:0] rresp_reg;
    } cfds_state_t;
endpackage

// ---- hdl/cfds_top.sv ----
// Notes on behaviour
// - Direction 1, response blocked by disabled lower transmitter: set flag, count discard.
// - Direction 0, response arriving on lower port sets unexpected-response flag.
// - CRC discard sets CRC flag; other errors of that frame stay unreported.
// - Byte error on final CRC byte sets both CRC and byte flags.
// - Each flag reads 0 with no error, 1 once its error was seen.
// - Separate 8-bit discard counters for UART, upper and lower ports.
// - Reading a discard register latches that port's counts, then clears its counters.
// - Valid UART frames counted in 16 bits, shown as high and low bytes.
// - Valid counter holds at 0xFFFF instead of wrapping.
`include "cfds_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cfds_top (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic DIR_SEL,
    input wire logic LOWER_RESP_RX,
    input wire logic LOWER_TX_OFF,
    input wire logic RESP_CRC_FAIL,
    input wire logic RESP_BYTE_ERR,
    input wire logic RESP_BYTE_LAST,
    input wire logic RESP_SOF_ERR,
    input wire logic UART_DISCARD,
    input wire logic UPPER_DISCARD,
    input wire logic LOWER_DISCARD,
    input wire logic UART_VALID,
    input wire cfds_pkg::cfds_addr_t S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire cfds_pkg::cfds_word_t S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire cfds_pkg::cfds_addr_t S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output cfds_pkg::cfds_word_t S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic IRQ
);
    import cfds_pkg::*;

    cfds_state_t s_reg;
    cfds_state_t s_next;
    logic ar_hs;
    logic [13:0] rd_idx;
    logic ev_txdis, ev_unexp, ev_crc, ev_byte, ev_sof;
    logic [2:0] ev_disc;
    logic [2:0] rd_disc;
    logic rd_flags;
    logic [4:0] ev_irq;
    logic wr_go;

    // Saturating byte increment
    function automatic logic [7:0] inc8(input logic [7:0] v, input logic en);
        inc8 = (en && v != `CFDS_MAX8) ? v + 8'h01 : v;
    endfunction

    // Frame events from the port engines
    assign ev_txdis = LOWER_RESP_RX & DIR_SEL & LOWER_TX_OFF;
    assign ev_unexp = LOWER_RESP_RX & ~DIR_SEL;
    assign ev_crc = RESP_CRC_FAIL | (RESP_BYTE_ERR & RESP_BYTE_LAST);
    assign ev_byte = RESP_BYTE_ERR & (RESP_BYTE_LAST | ~RESP_CRC_FAIL);
    assign ev_sof = RESP_SOF_ERR & ~RESP_CRC_FAIL;
    assign ev_disc[`CFDS_P_UART] = UART_DISCARD;
    assign ev_disc[`CFDS_P_UPPER] = UPPER_DISCARD;
    assign ev_disc[`CFDS_P_LOWER] = LOWER_DISCARD | ev_txdis | ev_crc;
    assign ev_irq = {|ev_disc, ev_txdis, ev_byte, ev_unexp, ev_crc};

    // Read decode at the address handshake
    assign ar_hs = S_AXI_ARVALID & ~s_reg.rvalid_reg;
    assign rd_idx = S_AXI_ARADDR[15:2];
    assign rd_flags = ar_hs && rd_idx == `CFDS_IDX_FLAGS;
    assign rd_disc[`CFDS_P_UART] = ar_hs && rd_idx == `CFDS_IDX_UART_DISC;
    assign rd_disc[`CFDS_P_UPPER] = ar_hs && rd_idx == `CFDS_IDX_UPPER_DISC;
    assign rd_disc[`CFDS_P_LOWER] = ar_hs && rd_idx == `CFDS_IDX_LOWER_DISC;
    assign wr_go = s_reg.aw_held_reg & s_reg.w_held_reg & ~s_reg.bvalid_reg;

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        // Sticky flags, cleared by a read, a new event wins
        if (rd_flags) begin
            s_next.flags_reg = `CFDS_ZERO8;
        end
        s_next.flags_reg[`CFDS_FLG_TXDIS] = s_next.flags_reg[`CFDS_FLG_TXDIS] | ev_txdis;
        s_next.flags_reg[`CFDS_FLG_UNEXP] = s_next.flags_reg[`CFDS_FLG_UNEXP] | ev_unexp;
        s_next.flags_reg[`CFDS_FLG_CRC] = s_next.flags_reg[`CFDS_FLG_CRC] | ev_crc;
        s_next.flags_reg[`CFDS_FLG_BYTE] = s_next.flags_reg[`CFDS_FLG_BYTE] | ev_byte;
        s_next.flags_reg[`CFDS_FLG_SOF] = s_next.flags_reg[`CFDS_FLG_SOF] | ev_sof;
        // Discard counters, latch and clear on read
        for (int i = 0; i < 3; i++) begin
            if (rd_disc[i]) begin
                s_next.disc_lat_reg[i] = s_reg.disc_cnt_reg[i];
                s_next.disc_cnt_reg[i] = inc8(`CFDS_ZERO8, ev_disc[i]);
            end else begin
                s_next.disc_cnt_reg[i] = inc8(s_reg.disc_cnt_reg[i], ev_disc[i]);
            end
        end
        // UART valid counter, saturating
        if (rd_disc[`CFDS_P_UART]) begin
            s_next.valid_lat_reg = s_reg.valid_cnt_reg;
            s_next.valid_cnt_reg = {`CFDS_ZERO8, inc8(`CFDS_ZERO8, UART_VALID)};
        end else if (UART_VALID && s_reg.valid_cnt_reg != `CFDS_MAX16) begin
            s_next.valid_cnt_reg = s_reg.valid_cnt_reg + 16'h0001;
        end
        // Interrupt status, read clears, event wins
        if (ar_hs && rd_idx == `CFDS_IDX_IRQ_STAT) begin
            s_next.irq_stat_reg = '0;
        end
        s_next.irq_stat_reg = s_next.irq_stat_reg | ev_irq;
        // Write channel capture in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            s_next.aw_held_reg = 1'b1;
            s_next.aw_idx_reg = S_AXI_AWADDR[15:2];
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            s_next.w_held_reg = 1'b1;
            s_next.wdata_reg = S_AXI_WDATA[7:0];
            s_next.wstrb0_reg = S_AXI_WSTRB[0];
        end
        // Write commit, only the mask is writable
        if (wr_go) begin
            s_next.aw_held_reg = 1'b0;
            s_next.w_held_reg = 1'b0;
            s_next.bvalid_reg = 1'b1;
            s_next.bresp_reg = `CFDS_RESP_OKAY;
            case (s_reg.aw_idx_reg)
                `CFDS_IDX_IRQ_MASK: begin
                    if (s_reg.wstrb0_reg) begin
                        s_next.irq_mask_reg = s_reg.wdata_reg[4:0];
                    end
                end
                `CFDS_IDX_FLAGS, `CFDS_IDX_UART_DISC, `CFDS_IDX_UPPER_DISC,
                `CFDS_IDX_LOWER_DISC, `CFDS_IDX_VALID_HI, `CFDS_IDX_VALID_LO,
                `CFDS_IDX_IRQ_STAT: begin
                    s_next.bresp_reg = `CFDS_RESP_OKAY;
                end
                default: begin
                    s_next.bresp_reg = `CFDS_RESP_SLVERR;
                end
            endcase
        end else if (s_reg.bvalid_reg && S_AXI_BREADY) begin
            s_next.bvalid_reg = 1'b0;
        end
        // Read answer, one cycle after the address
        if (ar_hs) begin
            s_next.rvalid_reg = 1'b1;
            s_next.rresp_reg = `CFDS_RESP_OKAY;
            s_next.rdata_reg = '0;
            case (rd_idx)
                `CFDS_IDX_FLAGS: s_next.rdata_reg[7:0] = s_reg.flags_reg;
                `CFDS_IDX_UART_DISC: s_next.rdata_reg[7:0] = s_reg.disc_cnt_reg[`CFDS_P_UART];
                `CFDS_IDX_UPPER_DISC: s_next.rdata_reg[7:0] = s_reg.disc_cnt_reg[`CFDS_P_UPPER];
                `CFDS_IDX_LOWER_DISC: s_next.rdata_reg[7:0] = s_reg.disc_cnt_reg[`CFDS_P_LOWER];
                `CFDS_IDX_VALID_HI: s_next.rdata_reg[7:0] = s_reg.valid_lat_reg[15:8];
                `CFDS_IDX_VALID_LO: s_next.rdata_reg[7:0] = s_reg.valid_lat_reg[7:0];
                `CFDS_IDX_IRQ_STAT: s_next.rdata_reg[4:0] = s_reg.irq_stat_reg;
                `CFDS_IDX_IRQ_MASK: s_next.rdata_reg[4:0] = s_reg.irq_mask_reg;
                default: s_next.rresp_reg = `CFDS_RESP_SLVERR;
            endcase
        end else if (s_reg.rvalid_reg && S_AXI_RREADY) begin
            s_next.rvalid_reg = 1'b0;
        end
    end

    // State register, everything zero on reset
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus and interrupt outputs
    assign S_AXI_AWREADY = ~s_reg.aw_held_reg & ~s_reg.bvalid_reg;
    assign S_AXI_WREADY = ~s_reg.w_held_reg & ~s_reg.bvalid_reg;
    assign S_AXI_BVALID = s_reg.bvalid_reg;
    assign S_AXI_BRESP = s_reg.bresp_reg;
    assign S_AXI_ARREADY = ~s_reg.rvalid_reg;
    assign S_AXI_RVALID = s_reg.rvalid_reg;
    assign S_AXI_RDATA = s_reg.rdata_reg;
    assign S_AXI_RRESP = s_reg.rresp_reg;
    assign IRQ = |(s_reg.irq_stat_reg & s_reg.irq_mask_reg);

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    txdis_flag_a: assert property (ev_txdis |=> s_reg.flags_reg[`CFDS_FLG_TXDIS]
        && (s_reg.disc_cnt_reg[`CFDS_P_LOWER] != $past(s_reg.disc_cnt_reg[`CFDS_P_LOWER])
        || $past(rd_disc[`CFDS_P_LOWER]) || $past(s_reg.disc_cnt_reg[`CFDS_P_LOWER]) == `CFDS_MAX8))
        else $error("blocked response not flagged or counted");
    unexp_flag_a: assert property (LOWER_RESP_RX && !DIR_SEL |=> s_reg.flags_reg[`CFDS_FLG_UNEXP])
        else $error("unexpected response not flagged");
    crc_hides_byte_a: assert property (RESP_CRC_FAIL && !RESP_BYTE_LAST && !rd_flags
        && !s_reg.flags_reg[`CFDS_FLG_BYTE] |=> s_reg.flags_reg[`CFDS_FLG_CRC]
        && !s_reg.flags_reg[`CFDS_FLG_BYTE]) else $error("error reported inside crc discard");
    last_byte_both_a: assert property (RESP_BYTE_ERR && RESP_BYTE_LAST |=>
        s_reg.flags_reg[`CFDS_FLG_CRC] && s_reg.flags_reg[`CFDS_FLG_BYTE])
        else $error("final byte error missing a flag");
    flags_sticky_a: assert property (!rd_flags |=> (s_reg.flags_reg & $past(s_reg.flags_reg))
        == $past(s_reg.flags_reg)) else $error("flag dropped without a read");
    disc_count_a: assert property (UPPER_DISCARD && !rd_disc[`CFDS_P_UPPER]
        && s_reg.disc_cnt_reg[`CFDS_P_UPPER] != `CFDS_MAX8 |=> s_reg.disc_cnt_reg[`CFDS_P_UPPER]
        == $past(s_reg.disc_cnt_reg[`CFDS_P_UPPER]) + 8'h01) else $error("discard not counted");
    latch_clear_a: assert property (rd_disc[`CFDS_P_UART] && !UART_DISCARD && !UART_VALID |=>
        s_reg.disc_cnt_reg[`CFDS_P_UART] == `CFDS_ZERO8 && s_reg.valid_cnt_reg == 16'h0000
        && s_reg.valid_lat_reg == $past(s_reg.valid_cnt_reg)
        && S_AXI_RDATA[7:0] == s_reg.disc_lat_reg[`CFDS_P_UART])
        else $error("discard read did not latch and clear");
    valid_count_a: assert property (UART_VALID && !rd_disc[`CFDS_P_UART]
        && s_reg.valid_cnt_reg != `CFDS_MAX16 |=> s_reg.valid_cnt_reg
        == $past(s_reg.valid_cnt_reg) + 16'h0001) else $error("valid frame not counted");
    valid_sat_a: assert property (s_reg.valid_cnt_reg == `CFDS_MAX16 && !rd_disc[`CFDS_P_UART]
        |=> s_reg.valid_cnt_reg == `CFDS_MAX16) else $error("valid counter wrapped");
    ro_write_a: assert property (wr_go && s_reg.aw_idx_reg != `CFDS_IDX_IRQ_MASK |=>
        S_AXI_BVALID && s_reg.irq_mask_reg == $past(s_reg.irq_mask_reg))
        else $error("write to read-only register had effect");
    read_answer_a: assert property (ar_hs |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read not answered next cycle");

    // Flag read with no event in the same cycle empties the register
    flags_clear_a: assert property (rd_flags && !ev_txdis && !ev_unexp && !ev_crc && !ev_byte
        && !ev_sof |=> s_reg.flags_reg == `CFDS_ZERO8)
        else $error("flag read did not clear");

    // Frame-start error flagged only outside a crc discard
    sof_flag_a: assert property (RESP_SOF_ERR && !RESP_CRC_FAIL |=>
        s_reg.flags_reg[`CFDS_FLG_SOF])
        else $error("frame start error not flagged");

    // Flag read returns the flags as they stood
    read_flags_a: assert property (ar_hs && rd_idx == `CFDS_IDX_FLAGS |=>
        S_AXI_RRESP == `CFDS_RESP_OKAY && S_AXI_RDATA[7:0] == $past(s_reg.flags_reg))
        else $error("flag read returned wrong data");

    // Discard counter holds at its ceiling
    disc_sat_a: assert property (s_reg.disc_cnt_reg[`CFDS_P_LOWER] == `CFDS_MAX8
        && !rd_disc[`CFDS_P_LOWER] |=> s_reg.disc_cnt_reg[`CFDS_P_LOWER] == `CFDS_MAX8)
        else $error("discard counter wrapped");

    // Upper port read latches and clears
    upper_latch_a: assert property (rd_disc[`CFDS_P_UPPER] && !UPPER_DISCARD |=>
        s_reg.disc_cnt_reg[`CFDS_P_UPPER] == `CFDS_ZERO8
        && s_reg.disc_lat_reg[`CFDS_P_UPPER] == $past(s_reg.disc_cnt_reg[`CFDS_P_UPPER]))
        else $error("upper discard read did not latch and clear");

    // Lower port read latches and clears
    lower_latch_a: assert property (rd_disc[`CFDS_P_LOWER] && !ev_disc[`CFDS_P_LOWER] |=>
        s_reg.disc_cnt_reg[`CFDS_P_LOWER] == `CFDS_ZERO8
        && s_reg.disc_lat_reg[`CFDS_P_LOWER] == $past(s_reg.disc_cnt_reg[`CFDS_P_LOWER]))
        else $error("lower discard read did not latch and clear");

    // Latched valid count moves only on a uart discard read
    latch_hold_a: assert property (!rd_disc[`CFDS_P_UART] |=>
        $stable(s_reg.valid_lat_reg))
        else $error("latched valid count changed");

    // Every event in ev_irq leaves its status bit set; a frame-start error has no status bit
    irq_set_a: assert property (|ev_irq |=>
        (s_reg.irq_stat_reg & $past(ev_irq)) == $past(ev_irq))
        else $error("interrupt status not set");

    // Status read with no event empties the status
    irq_clear_a: assert property (ar_hs && rd_idx == `CFDS_IDX_IRQ_STAT && ev_irq == '0 |=>
        s_reg.irq_stat_reg == '0)
        else $error("interrupt status not cleared by read");

    // Mask write lands with byte lane 0
    mask_write_a: assert property (wr_go && s_reg.aw_idx_reg == `CFDS_IDX_IRQ_MASK
        && s_reg.wstrb0_reg |=> s_reg.irq_mask_reg == $past(s_reg.wdata_reg[4:0]))
        else $error("mask write lost");

    // Write answered next cycle, channels closed meanwhile
    write_answer_a: assert property (wr_go |=>
        S_AXI_BVALID && !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write not answered next cycle");

    // Write response stands until taken
    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped early");

    // Read response stands until taken
    rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("read response dropped early");

    // Registers are one byte wide, upper read bits stay zero
    rdata_upper_a: assert property (S_AXI_RVALID |->
        S_AXI_RDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // Main scenarios
    txdis_seen_c: cover property (ev_txdis ##1 rd_flags);
    valid_sat_c: cover property (s_reg.valid_cnt_reg == `CFDS_MAX16 && UART_VALID);
    mask_write_c: cover property (wr_go && s_reg.aw_idx_reg == `CFDS_IDX_IRQ_MASK);
    disc_read_c: cover property (UART_DISCARD ##1 rd_disc[`CFDS_P_UART]);
    irq_rise_c: cover property (!IRQ ##1 IRQ);
endmodule
`default_nettype wire

// ---- tb/cfds_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far side: neighbouring monitors and UART host, seen as frame event lines
module cfds_far_end (
    input wire logic clk,
    output logic [10:0] ev
);
    // Idle low between frames
    initial ev = '0;
    // Hold one event pattern for n cycles, one frame per cycle
    task automatic fire(input logic [10:0] v, input int n);
        @(posedge clk);
        ev <= v;
        repeat (n) @(posedge clk);
        ev <= '0;
    endtask
endmodule
`default_nettype wire

// ---- tb/comm_frame_debug_stats_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cfds_consts.svh"
module comm_frame_debug_stats_tb;
    import cfds_pkg::*;
    logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [10:0] ev;
    cfds_addr_t awaddr, araddr;
    cfds_word_t wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int fails = 0, tests_run = 0, cycles = 0, n;
    logic [7:0] lower_exp;
    logic [13:0] idx_list [8] = '{14'h788, 14'h789, 14'h78a, 14'h78b, 14'h78c, 14'h78d,
        14'h7c0, 14'h7c1};
    logic [10:0] cases [8] = '{11'h700, 11'h600, 11'h200, 11'h090, 11'h0e0, 11'h040, 11'h010,
        11'h060};
    cfds_top DUT (.SYS_CLK(clk), .SRST(srst), .DIR_SEL(ev[10]), .LOWER_RESP_RX(ev[9]),
        .LOWER_TX_OFF(ev[8]), .RESP_CRC_FAIL(ev[7]), .RESP_BYTE_ERR(ev[6]),
        .RESP_BYTE_LAST(ev[5]), .RESP_SOF_ERR(ev[4]), .UART_DISCARD(ev[3]),
        .UPPER_DISCARD(ev[2]), .LOWER_DISCARD(ev[1]), .UART_VALID(ev[0]),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .IRQ(irq));
    cfds_far_end far (.clk(clk), .ev(ev));
    // Clock of 20 ns
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input cfds_word_t seen, input cfds_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write one word, release each channel as it is taken
    task automatic wr(input logic [13:0] idx, input cfds_word_t v);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask
    // Read one word
    task automatic rd(input logic [13:0] idx);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    // Flags expected after one response frame event
    function automatic cfds_word_t exp_flags(input logic [10:0] v);
        cfds_word_t f;
        f = '0;
        f[`CFDS_FLG_TXDIS] = v[10] & v[9] & v[8];
        f[`CFDS_FLG_UNEXP] = ~v[10] & v[9];
        f[`CFDS_FLG_CRC] = v[7] | (v[6] & v[5]);
        f[`CFDS_FLG_BYTE] = v[6] & (~v[7] | v[5]);
        f[`CFDS_FLG_SOF] = v[4] & ~v[7];
        return f;
    endfunction
    initial begin
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        n = $urandom(44);
        // Reset values, unmapped and read-only accesses
        foreach (idx_list[i]) begin
            rd(idx_list[i]);
            check(d, 32'h0);
        end
        rd(14'h0700);
        check(32'(r), 32'(`CFDS_RESP_SLVERR));
        check(d, 32'h0);
        wr(14'h0700, 32'h0);
        check(32'(r), 32'(`CFDS_RESP_SLVERR));
        wr(`CFDS_IDX_FLAGS, 32'hff);
        check(32'(r), 32'(`CFDS_RESP_OKAY));
        wr(`CFDS_IDX_UART_DISC, 32'hff);
        rd(`CFDS_IDX_FLAGS);
        check(d, 32'h0);
        rd(`CFDS_IDX_UART_DISC);
        check(d, 32'h0);
        $display("test reset_access done");
        // Each response error case, flags read back and cleared
        lower_exp = '0;
        foreach (cases[i]) begin
            far.fire(cases[i], 1);
            rd(`CFDS_IDX_FLAGS);
            check(d, exp_flags(cases[i]));
            if (cases[i][10:8] == 3'b111 || cases[i][7] || cases[i][6:5] == 2'b11) lower_exp++;
        end
        rd(`CFDS_IDX_IRQ_STAT);
        check(d, 32'h1f);
        rd(`CFDS_IDX_LOWER_DISC);
        check(d, 32'(lower_exp));
        $display("test error_flags done");
        // Interrupt masked and unmasked
        wr(`CFDS_IDX_IRQ_MASK, 32'h1);
        rd(`CFDS_IDX_IRQ_MASK);
        check(d, 32'h1);
        far.fire(11'h200, 1);
        @(negedge clk);
        check(32'(irq), 32'h0);
        far.fire(11'h090, 1);
        @(negedge clk);
        check(32'(irq), 32'h1);
        rd(`CFDS_IDX_IRQ_STAT);
        check(d, 32'h13);
        @(negedge clk);
        check(32'(irq), 32'h0);
        rd(`CFDS_IDX_FLAGS);
        check(d, 32'h03);
        rd(`CFDS_IDX_LOWER_DISC);
        check(d, 32'h1);
        $display("test interrupt done");
        // Random discard bursts per port, counter cleared by its read
        for (int p = 0; p < 3; p++) begin
            n = $urandom_range(270, 1);
            far.fire(11'h008 >> p, n);
            rd(14'(`CFDS_IDX_UART_DISC + p));
            check(d, 32'((n > 255) ? 255 : n));
            rd(14'(`CFDS_IDX_UART_DISC + p));
            check(d, 32'h0);
        end
        $display("test discard_counts done");
        // Valid frame count, latch and saturation
        n = $urandom_range(3000, 1);
        far.fire(11'h001, n);
        rd(`CFDS_IDX_UART_DISC);
        check(d, 32'h0);
        rd(`CFDS_IDX_VALID_HI);
        check(d, 32'(n[15:8]));
        rd(`CFDS_IDX_VALID_LO);
        check(d, 32'(n[7:0]));
        far.fire(11'h001, 65540);
        rd(`CFDS_IDX_VALID_LO);
        check(d, 32'(n[7:0]));
        rd(`CFDS_IDX_UART_DISC);
        check(d, 32'h0);
        rd(`CFDS_IDX_VALID_HI);
        check(d, 32'hff);
        rd(`CFDS_IDX_VALID_LO);
        check(d, 32'hff);
        $display("test valid_count done");
        close_out();
    end
endmodule
`default_nettype wire
